//--- dmr_pkg.sv
// constants and types shared by the data memory router
package dmr_pkg;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned STRETCH_W   = 3;
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned LOCAL_DEPTH = 1024;
  localparam logic [15:0] LOCAL_BASE  = 16'h0000;
  localparam logic [15:0] LOCAL_TOP   = 16'h03ff;
  localparam logic [15:0] SPACE_TOP   = 16'hffff;
  localparam int unsigned MC_CLKS     = 4;
  localparam int unsigned MIN_MC      = 2;
  localparam int unsigned MAX_MC      = 9;
  localparam int unsigned ALE_CLKS    = 2;
  localparam logic [15:0] PTR_RST     = 16'h0000;
  localparam logic        LRE_RST     = 1'b0;
  localparam logic [7:0]  P0_ADDR_OE  = 8'hff;

  typedef enum logic [1:0] {
    DMR_P0_LOW,
    DMR_P0_HIGH,
    DMR_P1_LOW,
    DMR_P1_HIGH
  } dmr_ptr_byte_e;

  typedef struct packed {
    logic              write;
    logic              use_ptr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmr_req_s;

  typedef struct packed {
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p2_out;
    logic       p2_oe;
    logic       ale;
    logic       wr_n;
    logic       rd_n;
  } dmr_pins_s;
endpackage : dmr_pkg

//--- dmr_sram.sv
// on-chip data sram, flip-flop storage with registered read
`timescale 1ns/1ps
module dmr_sram #(
  parameter int unsigned DEPTH = 1024,
  parameter int unsigned AW    = 10,
  parameter int unsigned DW    = 8
) (
  input  wire logic          clk,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  if (DEPTH != (1 << AW)) begin : g_depth_chk
    $error("dmr_sram: DEPTH must be 2**AW");
  end

  // data storage carries no reset: contents are undefined after power-up
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (en && !we) begin
      rdata <= mem[addr];
    end
  end
endmodule : dmr_sram

//--- dmr_router.sv
// data memory access router: local sram, external bus, dual pointers
// Overview of operation
// - 1KB local sram sits at 0000h-03ffh, reached only by data moves.
// - with local sram enabled, addresses inside 1KB are served locally.
// - addresses above 03ffh always go out on low and high ports.
// - with local sram disabled, all 64K goes external; disabled by default.
// - local ram enable bit set by software, cleared by any reset.
// - external access length selectable from two to nine machine cycles.
// - one machine cycle is four clocks; bus timing counted in them.
// - two independent 16-bit pointers, each kept as low and high byte.
// - decrement op lowers the active pointer by one with borrow.
// - low port muxes address low and data; high port drives address high.
// - low port drives push-pull on bus, open-drain port otherwise.
// - with wait enabled, port4 bit0 is input only, carrying wait.
// - scratchpad ram is separate and never decoded here.
// - external data space is 64K with a 16-bit address.
// - pointer select one chooses second pointer, zero the first.
// - address latch strobe pulses before low port carries data.
// - active-low write and read strobes for external memory.
`timescale 1ns/1ps
module dmr_router (
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  REQ,
  input  wire dmr_pkg::dmr_req_s     REQ_INFO,
  input  wire logic [2:0]            STRETCH,
  input  wire logic                  LRE_WR,
  input  wire logic                  LRE_VAL,
  input  wire logic                  POINTER_SELECT,
  input  wire logic                  PTR_WR,
  input  wire dmr_pkg::dmr_ptr_byte_e PTR_WR_SEL,
  input  wire logic [7:0]            PTR_WR_DATA,
  input  wire logic                  PTR_DEC,
  input  wire logic                  WAIT_EN,
  input  wire logic                  WAIT_N_PIN,
  input  wire logic [7:0]            P0_IN,
  input  wire logic [7:0]            P0_LATCH,
  output logic                       BUSY,
  output logic                       DONE,
  output logic [7:0]                 RDATA,
  output logic                       LOCAL_RAM_ENABLE,
  output logic [15:0]                POINTER0,
  output logic [15:0]                POINTER1,
  output logic                       P40_OUT_ALLOW,
  output logic [7:0]                 P0_OUT,
  output logic [7:0]                 P0_OE,
  output logic [7:0]                 P2_OUT,
  output logic                       P2_OE,
  output logic                       ALE,
  output logic                       WR_N,
  output logic                       RD_N
);
  import dmr_pkg::*;

  typedef enum logic [1:0] {DMR_IDLE, DMR_EXT, DMR_LOC} dmr_state_e;

  function automatic logic is_local(input logic en, input logic [15:0] a);
    return en && (a >= LOCAL_BASE) && (a <= LOCAL_TOP);
  endfunction : is_local

  function automatic logic [CNT_W-1:0] ext_clks(input logic [2:0] s);
    return CNT_W'((MIN_MC + 32'(s)) * MC_CLKS);
  endfunction : ext_clks

  if (ext_clks(3'h7) != CNT_W'(MAX_MC * MC_CLKS)) begin : g_len_chk
    $error("dmr_router: stretch range does not reach the longest access");
  end

  dmr_state_e       state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] total;
  logic             is_write;
  logic [7:0]       wdata;
  logic             wait_meta;
  logic             wait_sync;
  logic [7:0]       p0_meta;
  logic [7:0]       p0_sync;
  logic [15:0]      req_addr;
  logic             hit;
  logic             take;
  logic [CNT_W-1:0] next_cnt;
  logic             hold;
  logic [7:0]       sram_rdata;
  dmr_pins_s        next_pins;

  assign req_addr = REQ_INFO.use_ptr ? (POINTER_SELECT ? POINTER1 : POINTER0)
                                     : REQ_INFO.addr;
  assign hit  = is_local(LOCAL_RAM_ENABLE, req_addr);
  assign take = (state == DMR_IDLE) && REQ;
  // wait stretches the strobe only while enabled
  assign hold = WAIT_EN && !wait_sync && (cnt == total - CNT_W'(2));
  assign next_cnt = hold ? cnt : cnt + CNT_W'(1);

  // pin inputs pass two flops before use
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      // idle pin level is high: no false wait right after reset
      wait_meta <= 1'b1;
      wait_sync <= 1'b1;
      p0_meta   <= 8'h00;
      p0_sync   <= 8'h00;
    end else begin
      wait_meta <= WAIT_N_PIN;
      wait_sync <= wait_meta;
      p0_meta   <= P0_IN;
      p0_sync   <= p0_meta;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LOCAL_RAM_ENABLE <= LRE_RST;
    end else if (LRE_WR) begin
      LOCAL_RAM_ENABLE <= LRE_VAL;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      P40_OUT_ALLOW <= 1'b1;
    end else begin
      // bit0 of port4 becomes input only while wait is enabled
      P40_OUT_ALLOW <= !WAIT_EN;
    end
  end

  // pointers; a byte write wins over a decrement that cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      POINTER0 <= PTR_RST;
      POINTER1 <= PTR_RST;
    end else if (PTR_WR) begin
      unique case (PTR_WR_SEL)
        DMR_P0_LOW:  POINTER0[7:0]  <= PTR_WR_DATA;
        DMR_P0_HIGH: POINTER0[15:8] <= PTR_WR_DATA;
        DMR_P1_LOW:  POINTER1[7:0]  <= PTR_WR_DATA;
        DMR_P1_HIGH: POINTER1[15:8] <= PTR_WR_DATA;
      endcase
    end else if (PTR_DEC) begin
      if (POINTER_SELECT) begin
        POINTER1 <= POINTER1 - 16'h0001;
      end else begin
        POINTER0 <= POINTER0 - 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state    <= DMR_IDLE;
      cnt      <= '0;
      total    <= '0;
      is_write <= 1'b0;
      wdata    <= 8'h00;
      BUSY     <= 1'b0;
      DONE     <= 1'b0;
      RDATA    <= 8'h00;
    end else begin
      DONE <= 1'b0;
      unique case (state)
        DMR_IDLE: begin
          if (take) begin
            state    <= hit ? DMR_LOC : DMR_EXT;
            cnt      <= '0;
            total    <= ext_clks(STRETCH);
            is_write <= REQ_INFO.write;
            wdata    <= REQ_INFO.wdata;
            BUSY     <= 1'b1;
          end
        end
        DMR_LOC: begin
          state <= DMR_IDLE;
          BUSY  <= 1'b0;
          DONE  <= 1'b1;
          if (!is_write) begin
            RDATA <= sram_rdata;
          end
        end
        DMR_EXT: begin
          cnt <= next_cnt;
          // sample on the last strobe clock, data settled through sync
          if (!is_write && cnt == total - CNT_W'(2) && !hold) begin
            RDATA <= p0_sync;
          end
          if (cnt == total - CNT_W'(1)) begin
            state <= DMR_IDLE;
            BUSY  <= 1'b0;
            DONE  <= 1'b1;
          end
        end
      endcase
    end
  end

  // only this port reaches the sram; no scratchpad decode here
  dmr_sram #(
    .DEPTH (LOCAL_DEPTH),
    .AW    (10),
    .DW    (DATA_W)
  ) u_sram (
    .clk   (CLK),
    .en    (take && hit),
    .we    (REQ_INFO.write),
    .addr  (req_addr[9:0]),
    .wdata (REQ_INFO.wdata),
    .rdata (sram_rdata)
  );

  // pin values for the coming clock
  always_comb begin
    next_pins.p0_out = 8'h00;
    // idle low port is open drain: drive only zeros
    next_pins.p0_oe  = ~P0_LATCH;
    next_pins.p2_out = P2_OUT;
    next_pins.p2_oe  = 1'b0;
    next_pins.ale    = 1'b0;
    next_pins.wr_n   = 1'b1;
    next_pins.rd_n   = 1'b1;
    if (take && !hit) begin
      next_pins.p0_out = req_addr[7:0];
      next_pins.p0_oe  = P0_ADDR_OE;
      next_pins.p2_out = req_addr[15:8];
      next_pins.p2_oe  = 1'b1;
      next_pins.ale    = 1'b1;
    end else if (state == DMR_EXT && cnt != total - CNT_W'(1)) begin
      next_pins.p2_oe = 1'b1;
      next_pins.ale   = next_cnt < CNT_W'(ALE_CLKS);
      if (next_cnt < CNT_W'(MC_CLKS)) begin
        next_pins.p0_out = P0_OUT;
        next_pins.p0_oe  = P0_ADDR_OE;
      end else begin
        // push-pull data while acting as bus
        next_pins.p0_out = is_write ? wdata : 8'h00;
        next_pins.p0_oe  = is_write ? P0_ADDR_OE : 8'h00;
        // strobes cover the data phase, released one clock before end
        if (next_cnt <= total - CNT_W'(2)) begin
          next_pins.wr_n = !is_write;
          next_pins.rd_n = is_write;
        end
      end
    end
  end

  // local accesses never reach these pins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      P0_OUT <= 8'h00;
      P0_OE  <= 8'h00;
      P2_OUT <= 8'h00;
      P2_OE  <= 1'b0;
      ALE    <= 1'b0;
      WR_N   <= 1'b1;
      RD_N   <= 1'b1;
    end else begin
      P0_OUT <= next_pins.p0_out;
      P0_OE  <= next_pins.p0_oe;
      P2_OUT <= next_pins.p2_out;
      P2_OE  <= next_pins.p2_oe;
      ALE    <= next_pins.ale;
      WR_N   <= next_pins.wr_n;
      RD_N   <= next_pins.rd_n;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  local_no_strobe_a: assert property (
    take && hit |=> (WR_N && RD_N && !ALE && !P2_OE) [*2])
    else $error("local access produced an external strobe");
  high_goes_out_a: assert property (
    take && req_addr > LOCAL_TOP |=> ALE && P2_OE && P2_OUT == $past(req_addr[15:8]))
    else $error("address above local window not sent out");
  disabled_all_out_a: assert property (
    take && !LOCAL_RAM_ENABLE |=> state == DMR_EXT)
    else $error("disabled local ram still took an access");
  reset_clears_en_a: assert property (
    $rose(ARST_N) |-> !LOCAL_RAM_ENABLE)
    else $error("enable bit not clear after reset");
  ext_length_a: assert property (
    take && !hit && !WAIT_EN && STRETCH == 3'h0 |=> !DONE [*8] ##1 DONE)
    else $error("shortest external access not two machine cycles");
  ale_first_a: assert property (
    $rose(ALE) |=> ALE ##1 !ALE && WR_N && RD_N)
    else $error("latch strobe overlaps data phase");
  decrement_a: assert property (
    PTR_DEC && !PTR_WR && !POINTER_SELECT |=> POINTER0 == $past(POINTER0) - 16'h0001)
    else $error("pointer decrement wrong");
  write_strobe_data_a: assert property (
    !WR_N |-> P0_OE == P0_ADDR_OE && RD_N)
    else $error("write strobe without driven data");
  read_release_a: assert property (
    !RD_N |-> P0_OE == 8'h00)
    else $error("low port driven during read");
  wait_input_a: assert property (
    WAIT_EN |=> !P40_OUT_ALLOW)
    else $error("wait pin still allowed to drive");

  local_read_c: cover property (take && hit && !REQ_INFO.write ##2 DONE);
  ext_write_c:  cover property (take && !hit && REQ_INFO.write ##[9:37] DONE);
  ext_wait_c:   cover property (hold [*3] ##1 !hold);
  ptr_dec_c:    cover property (PTR_DEC && POINTER_SELECT && POINTER1[7:0] == 8'h00);
endmodule : dmr_router

//--- dmr_ext_mem.sv
// behavioural external data memory on the multiplexed bus
`timescale 1ns/1ps
module dmr_ext_mem (
  input  wire logic       clk,
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p2_out,
  input  wire logic       ale,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  output logic      [7:0] drv,
  output logic            drv_en
);
  logic [7:0]  mem [logic [15:0]];
  logic [15:0] adr;
  logic [7:0]  last;
  initial last = 8'h00;
  always @(negedge ale) adr = {p2_out, p0_out};
  // take data at write strobe end
  always @(posedge wr_n) mem[adr] = p0_out;
  assign drv_en = !rd_n;
  always @(negedge rd_n) last = mem.exists(adr) ? mem[adr] : 8'h5a;
  // released bus shows the inverse, not a held value
  assign drv = drv_en ? last : ~last;
endmodule : dmr_ext_mem

//--- tb_top.sv
// self-checking bench for the data memory router
`timescale 1ns/1ps
module tb_top;
  import dmr_pkg::*;
  logic CLK, ARST_N, REQ, LRE_WR, LRE_VAL, POINTER_SELECT, PTR_WR, PTR_DEC;
  logic WAIT_EN, WAIT_N_PIN, BUSY, DONE, LRE, P40, P2_OE, ALE, WR_N, RD_N;
  logic [2:0]  STRETCH;
  logic [7:0]  PTR_WR_DATA, P0_IN, P0_LATCH, RDATA, P0_OUT, P0_OE, P2_OUT;
  logic [7:0]  mq, q;
  logic [15:0] POINTER0, POINTER1, a;
  logic        men, ext_seen;
  dmr_req_s      REQ_INFO;
  dmr_ptr_byte_e PTR_WR_SEL;
  int errors, compares, n;
  dmr_router dut (.CLK(CLK), .ARST_N(ARST_N), .REQ(REQ), .REQ_INFO(REQ_INFO),
    .STRETCH(STRETCH), .LRE_WR(LRE_WR), .LRE_VAL(LRE_VAL),
    .POINTER_SELECT(POINTER_SELECT), .PTR_WR(PTR_WR),
    .PTR_WR_SEL(PTR_WR_SEL), .PTR_WR_DATA(PTR_WR_DATA), .PTR_DEC(PTR_DEC),
    .WAIT_EN(WAIT_EN), .WAIT_N_PIN(WAIT_N_PIN), .P0_IN(P0_IN),
    .P0_LATCH(P0_LATCH), .BUSY(BUSY), .DONE(DONE), .RDATA(RDATA),
    .LOCAL_RAM_ENABLE(LRE), .POINTER0(POINTER0), .POINTER1(POINTER1),
    .P40_OUT_ALLOW(P40), .P0_OUT(P0_OUT), .P0_OE(P0_OE), .P2_OUT(P2_OUT),
    .P2_OE(P2_OE), .ALE(ALE), .WR_N(WR_N), .RD_N(RD_N));
  dmr_ext_mem mem (.clk(CLK), .p0_out(P0_OUT), .p2_out(P2_OUT), .ale(ALE),
    .wr_n(WR_N), .rd_n(RD_N), .drv(mq), .drv_en(men));
  // open-drain low port: undriven bits show the inverse of the last value
  assign P0_IN = men ? mq : ((P0_OE & P0_OUT) | (~P0_OE & mq));
  always @(negedge RD_N or negedge WR_N) ext_seen = 1'b1;
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  function automatic logic exp_ext(input logic en, input logic [15:0] ad);
    return !(en && ad <= LOCAL_TOP);
  endfunction : exp_ext
  // negedges counted from the take edge through the done cycle
  function automatic logic [15:0] exp_len(input logic [2:0] s);
    return 16'((s + 2) * MC_CLKS + 1);
  endfunction : exp_len
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic acc(input logic w, input logic up, input logic [15:0] ad,
                     input logic [7:0] d, input logic [2:0] s);
    @(posedge CLK);
    ext_seen = 1'b0;
    n = 0;
    REQ <= 1'b1;
    REQ_INFO <= '{write: w, use_ptr: up, addr: ad, wdata: d};
    STRETCH <= s;
    @(posedge CLK);
    REQ <= 1'b0;
    do begin
      @(negedge CLK);
      n++;
      if (n == 1) chk(16'(BUSY), 16'h1);
    end while (DONE !== 1'b1 && n < 400);
    chk(16'(DONE), 16'h1);
    chk(16'(BUSY), 16'h0);
    q = RDATA;
  endtask : acc
  task automatic pw(input dmr_ptr_byte_e sel, input logic [7:0] d);
    @(posedge CLK);
    PTR_WR <= 1'b1;
    PTR_WR_SEL <= sel;
    PTR_WR_DATA <= d;
    @(posedge CLK);
    PTR_WR <= 1'b0;
  endtask : pw
  task automatic pdec();
    @(posedge CLK);
    PTR_DEC <= 1'b1;
    @(posedge CLK);
    PTR_DEC <= 1'b0;
    @(negedge CLK);
  endtask : pdec
  task automatic lre_set(input logic v);
    @(posedge CLK);
    LRE_WR <= 1'b1;
    LRE_VAL <= v;
    @(posedge CLK);
    LRE_WR <= 1'b0;
    @(negedge CLK);
  endtask : lre_set
  initial begin
    #1_000_000;
    errors++;
    end_sim();
  end
  initial begin
    logic [7:0] d;
    {ARST_N, REQ, LRE_WR, LRE_VAL, POINTER_SELECT, PTR_WR, PTR_DEC} = '0;
    {WAIT_EN, STRETCH, PTR_WR_DATA} = '0;
    WAIT_N_PIN = 1'b1;
    REQ_INFO = '0;
    PTR_WR_SEL = DMR_P0_LOW;
    void'($urandom(32'h6ed8));
    P0_LATCH = 8'($urandom());
    repeat (12) @(posedge CLK);
    ARST_N <= 1'b1;
    @(negedge CLK);
    chk(LRE, LRE_RST);
    chk(POINTER1, PTR_RST);
    // default routing and every stretch code
    for (int s = 0; s < 8; s++) begin
      d = 8'($urandom());
      a = 16'($urandom()) & 16'h03ff;
      acc(1'b1, 1'b0, a, d, 3'(s));
      chk(16'(n), exp_len(3'(s)));
      acc(1'b0, 1'b0, a, 8'h00, 3'(s));
      chk(16'(ext_seen), 16'h1);
      chk(q, d);
    end
    lre_set(1'b1);
    chk(LRE, 1'b1);
    // random mix of local and external addresses, both sides of the window top forced
    for (int i = 0; i < 40; i++) begin
      a = i == 0 ? LOCAL_TOP : i == 1 ? 16'h0400 : 16'($urandom());
      d = 8'($urandom());
      acc(1'b1, 1'b0, a, d, 3'($urandom()));
      acc(1'b0, 1'b0, a, 8'h00, 3'($urandom()));
      chk(q, d);
      chk(16'(ext_seen), 16'(exp_ext(LRE, a)));
      if (!exp_ext(LRE, a)) chk(16'(n), 16'h2);
    end
    // pointers: independent bytes, select, decrement with borrow
    pw(DMR_P0_LOW, 8'h00);
    pw(DMR_P0_HIGH, 8'h00);
    pw(DMR_P1_LOW, 8'h00);
    pw(DMR_P1_HIGH, 8'h12);
    POINTER_SELECT <= 1'b1;
    pdec();
    chk(POINTER1, 16'h11ff);
    chk(POINTER0, 16'h0000);
    acc(1'b1, 1'b1, 16'h0000, 8'ha7, 3'h0);
    acc(1'b0, 1'b0, 16'h11ff, 8'h00, 3'h1);
    chk(q, 8'ha7);
    @(posedge CLK);
    POINTER_SELECT <= 1'b0;
    pdec();
    chk(POINTER0, 16'hffff);
    chk(POINTER1, 16'h11ff);
    // wait request stretches the strobe
    @(posedge CLK);
    WAIT_EN <= 1'b1;
    fork
      acc(1'b0, 1'b0, 16'h8000, 8'h00, 3'h0);
      begin
        @(posedge CLK);
        WAIT_N_PIN <= 1'b0;
        repeat (10) @(posedge CLK);
        WAIT_N_PIN <= 1'b1;
      end
    join
    chk(16'(n >= 12), 16'h1);
    chk(P40, 1'b0);
    @(posedge CLK);
    WAIT_EN <= 1'b0;
    // second reset drops the enable and the pointers
    @(posedge CLK);
    ARST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    @(negedge CLK);
    chk(LRE, 1'b0);
    chk(POINTER0, PTR_RST);
    end_sim();
  end
endmodule : tb_top
